// >>> shared/aswr_pkg.sv
// Package of register map, read codes, field positions and timing for angle working registers
package aswr_pkg;

  // ==========================================================================
  // Register offsets
  localparam logic [7:0] OFS_STATUS   = 8'h00;
  localparam logic [7:0] OFS_ANGLE    = 8'h02;
  localparam logic [7:0] OFS_SPEED    = 8'h03;
  localparam logic [7:0] OFS_COSINE   = 8'h06;
  localparam logic [7:0] OFS_SINE     = 8'h07;
  localparam logic [7:0] OFS_TEMP     = 8'h0a;

  // ==========================================================================
  // Read command codes
  localparam logic [15:0] CMD_STATUS  = 16'hc001;
  localparam logic [15:0] CMD_ANGLE   = 16'h8021;
  localparam logic [15:0] CMD_SPEED   = 16'hc031;
  localparam logic [15:0] CMD_COSINE  = 16'hc061;
  localparam logic [15:0] CMD_SINE    = 16'h8071;
  localparam logic [15:0] CMD_TEMP    = 16'hc0a1;

  // ==========================================================================
  // Field positions
  localparam int BIT_REFRESHED     = 15;
  localparam int BIT_IF_FAULT      = 13;
  localparam int BIT_VEC_FAULT     = 12;
  localparam int BIT_NVM_FAULT     = 9;
  localparam int BIT_CRC_FAULT     = 8;
  localparam int BIT_CORE_FAULT    = 7;
  localparam int BIT_SELFTEST      = 6;
  localparam int BIT_TEMP_FAULT    = 5;
  localparam int BIT_ADC_FAULT     = 4;
  localparam int BIT_SUPPLY_FAULT  = 3;
  localparam int BIT_WDOG          = 2;
  localparam int BIT_REDUNDANCY    = 1;
  localparam int BIT_RESET_SEEN    = 0;
  localparam int BIT_TEMP_FSM      = 5;
  localparam int BIT_TEMP_INT      = 4;
  localparam int ANGLE_W           = 15;
  localparam int SPEED_W           = 12;
  localparam int TEMP_W            = 10;
  localparam int TEMP_LSB          = 6;

  // ==========================================================================
  // Reset values and timing
  localparam logic [15:0] RESET_WORD  = 16'h0000;
  localparam int          UPDATE_NS   = 25000;
  localparam int          CLK_NS      = 10;
  localparam int          UPDATE_CYC  = UPDATE_NS / CLK_NS;

  // ==========================================================================
  // Carriers
  typedef struct packed {
    logic if_fault;
    logic vector_magnitude_fault;
    logic nvm_fault;
    logic crc_fault;
    logic processing_core_fault;
    logic selftest_fault;
    logic temperature_fault;
    logic adc_fault;
    logic supply_fault;
    logic watchdog_reset_seen;
    logic redundancy_mismatch;
    logic reset_seen;
  } aswr_flags_t;

  typedef struct packed {
    logic [ANGLE_W-1:0] angle_word;
    logic [SPEED_W-1:0] rotation_rate;
    logic [15:0]        cosine;
    logic [15:0]        sine;
    logic [TEMP_W-1:0]  temperature;
  } aswr_sample_t;

  typedef enum logic [2:0] {
    SEL_NONE, SEL_STATUS, SEL_ANGLE, SEL_SPEED, SEL_COSINE, SEL_SINE, SEL_TEMP
  } aswr_sel_t;

endpackage

// >>> hw/aswr_regs.sv
// Working register set of the angle sensor, read by command code from the calibration port
// Overview of operation
// - Status bit 15 set when status flags refreshed since last status read.
// - Status bit 13 shows an output interface problem.
// - Status bit 12 shows sine/cosine vector magnitude out of limits.
// - Status bit 9 shows a nonvolatile memory error.
// - Status bit 8 shows any bit-error detection alarm.
// - Status bit 7 shows a processing core execution fault.
// - Status bit 6 shows a failed power-up self test.
// - Status bit 5 shows temperature out of limits or delta check failure.
// - Status bit 4 shows converter raw checks or filter scheduling alarm.
// - Status bit 3 combines the supply voltage monitors.
// - Status bit 2 shows last reset came from the watchdog.
// - Status bit 1 shows redundant angle computation disagreement.
// - Angle register refreshes once per update period of about 25 us.
// - Angle is a signed 15-bit value in bits 14 to 0.
// - Angle bit 15 set when refreshed since last interface read.
// - Speed is signed 12-bit in bits 11 to 0, bits 14 to 12 zero.
// - Speed bit 15 set when refreshed since last interface read.
// - Cosine raw reading fills the whole 16-bit register.
// - Sine raw reading fills the whole 16-bit register.
// - Temperature 10-bit reading in bits 15 to 6, bits 3 to 0 reserved.
// - Temperature bit 5 set while new value unconsumed by internal machine.
// - Temperature bit 4 set while new value unread by the interface.
module aswr_regs
  import aswr_pkg::*;
#(
  parameter int UPDATE_CYCLES = UPDATE_CYC
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // Measurement side, same clock domain
  input  wire aswr_flags_t  flags_in,
  input  wire aswr_sample_t sample_in,
  input  wire logic         temp_fsm_take,
  // Command port from the calibration port decoder
  input  wire logic         cmd_valid,
  input  wire logic [15:0]  cmd_code,
  // Answer
  output logic              rd_valid_q,
  output logic [15:0]       rd_data_q,
  output logic              update_q
);

  // ==========================================================================
  // Update period timer
  localparam int TW = $clog2(UPDATE_CYCLES + 1);
  logic [TW-1:0] tick_cnt_q;
  logic          tick;

  assign tick = (tick_cnt_q == TW'(UPDATE_CYCLES - 1));

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      tick_cnt_q <= '0;
    end else if (tick) begin
      tick_cnt_q <= '0;
    end else begin
      tick_cnt_q <= tick_cnt_q + TW'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      update_q <= 1'b0;
    end else begin
      update_q <= tick;
    end
  end

  // Cycles since the last update pulse, for the period checks
  logic [TW-1:0] gap_cnt_q;
  logic          gap_seen_q;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      gap_cnt_q  <= '0;
      gap_seen_q <= 1'b0;
    end else if (update_q) begin
      gap_cnt_q  <= '0;
      gap_seen_q <= 1'b1;
    end else if (gap_cnt_q != TW'(UPDATE_CYCLES)) begin
      gap_cnt_q <= gap_cnt_q + TW'(1);
    end
  end

  first_update_a: assert property (@(posedge clk) disable iff (!rst_n)
    update_q && !gap_seen_q |-> gap_cnt_q == TW'(UPDATE_CYCLES))
    else $error("first update pulse at wrong cycle");

  update_gap_a: assert property (@(posedge clk) disable iff (!rst_n)
    update_q && gap_seen_q |-> gap_cnt_q == TW'(UPDATE_CYCLES - 1))
    else $error("update period wrong");

  update_late_a: assert property (@(posedge clk) disable iff (!rst_n)
    !update_q |-> gap_cnt_q < (gap_seen_q ? TW'(UPDATE_CYCLES - 1) : TW'(UPDATE_CYCLES)))
    else $error("update pulse missing");

  // ==========================================================================
  // Command decode
  function automatic aswr_sel_t decode(input logic [15:0] code);
    case (code)
      CMD_STATUS: decode = SEL_STATUS;
      CMD_ANGLE:  decode = SEL_ANGLE;
      CMD_SPEED:  decode = SEL_SPEED;
      CMD_COSINE: decode = SEL_COSINE;
      CMD_SINE:   decode = SEL_SINE;
      CMD_TEMP:   decode = SEL_TEMP;
      default:    decode = SEL_NONE;
    endcase
  endfunction

  aswr_sel_t sel;
  logic      rd_status, rd_angle, rd_speed, rd_temp;

  assign sel       = cmd_valid ? decode(cmd_code) : SEL_NONE;
  assign rd_status = (sel == SEL_STATUS);
  assign rd_angle  = (sel == SEL_ANGLE);
  assign rd_speed  = (sel == SEL_SPEED);
  assign rd_temp   = (sel == SEL_TEMP);

  // ==========================================================================
  // Captured working values
  aswr_flags_t  flags_q;
  aswr_sample_t sample_q;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      flags_q  <= '0;
      sample_q <= '0;
    end else if (tick) begin
      flags_q  <= flags_in;
      sample_q <= sample_in;
    end
  end

  flag_capture_a: assert property (@(posedge clk) disable iff (!rst_n)
    tick |=> flags_q == $past(flags_in))
    else $error("fault flags not captured at update");

  sample_capture_a: assert property (@(posedge clk) disable iff (!rst_n)
    tick |=> sample_q == $past(sample_in))
    else $error("sample not captured at update");

  // ==========================================================================
  // Refreshed flags; an update in the same cycle as a read wins
  logic st_fresh_q, ang_fresh_q, spd_fresh_q, tmp_int_q, tmp_fsm_q;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_fresh_q  <= 1'b0;
      ang_fresh_q <= 1'b0;
      spd_fresh_q <= 1'b0;
      tmp_int_q   <= 1'b0;
    end else begin
      st_fresh_q  <= tick | (st_fresh_q & ~rd_status);
      ang_fresh_q <= tick | (ang_fresh_q & ~rd_angle);
      spd_fresh_q <= tick | (spd_fresh_q & ~rd_speed);
      tmp_int_q   <= tick | (tmp_int_q & ~rd_temp);
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      tmp_fsm_q <= 1'b0;
    end else begin
      tmp_fsm_q <= tick | (tmp_fsm_q & ~temp_fsm_take);
    end
  end

  status_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
    rd_status && !tick |=> !st_fresh_q)
    else $error("status refreshed flag not cleared by read");

  speed_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
    rd_speed && !tick |=> !spd_fresh_q)
    else $error("speed refreshed flag not cleared by read");

  temp_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
    rd_temp && !tick |=> !tmp_int_q)
    else $error("temperature interface flag not cleared by read");

  angle_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
    !tick && !rd_angle |=> ang_fresh_q == $past(ang_fresh_q))
    else $error("angle refreshed flag changed without cause");

  fsm_set_a: assert property (@(posedge clk) disable iff (!rst_n)
    tick |=> tmp_fsm_q)
    else $error("internal fresh flag not set by update");

  // ==========================================================================
  // Word assembly
  logic [15:0] status_word, angle_word, speed_word, temp_word, rd_mux;

  always_comb begin
    status_word                   = RESET_WORD;
    status_word[BIT_REFRESHED]    = st_fresh_q;
    status_word[BIT_IF_FAULT]     = flags_q.if_fault;
    status_word[BIT_VEC_FAULT]    = flags_q.vector_magnitude_fault;
    status_word[BIT_NVM_FAULT]    = flags_q.nvm_fault;
    status_word[BIT_CRC_FAULT]    = flags_q.crc_fault;
    status_word[BIT_CORE_FAULT]   = flags_q.processing_core_fault;
    status_word[BIT_SELFTEST]     = flags_q.selftest_fault;
    status_word[BIT_TEMP_FAULT]   = flags_q.temperature_fault;
    status_word[BIT_ADC_FAULT]    = flags_q.adc_fault;
    status_word[BIT_SUPPLY_FAULT] = flags_q.supply_fault;
    status_word[BIT_WDOG]         = flags_q.watchdog_reset_seen;
    status_word[BIT_REDUNDANCY]   = flags_q.redundancy_mismatch;
    status_word[BIT_RESET_SEEN]   = flags_q.reset_seen;
  end

  assign angle_word = {ang_fresh_q, sample_q.angle_word};
  assign speed_word = {spd_fresh_q, 3'h0, sample_q.rotation_rate};
  assign temp_word  = {sample_q.temperature, tmp_fsm_q, tmp_int_q, 4'h0};

  always_comb begin
    case (sel)
      SEL_STATUS: rd_mux = status_word;
      SEL_ANGLE:  rd_mux = angle_word;
      SEL_SPEED:  rd_mux = speed_word;
      SEL_COSINE: rd_mux = sample_q.cosine;
      SEL_SINE:   rd_mux = sample_q.sine;
      SEL_TEMP:   rd_mux = temp_word;
      default:    rd_mux = RESET_WORD;
    endcase
  end

  // ==========================================================================
  // Answer register; flags shown are those before the read clears them
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rd_valid_q <= 1'b0;
      rd_data_q  <= RESET_WORD;
    end else begin
      rd_valid_q <= cmd_valid;
      rd_data_q  <= rd_mux;
    end
  end

  // ==========================================================================
  // Checks
  read_clears_a: assert property (@(posedge clk) disable iff (!rst_n)
    rd_angle && !tick |=> !ang_fresh_q)
    else $error("angle refreshed flag not cleared by read");

  update_sets_a: assert property (@(posedge clk) disable iff (!rst_n)
    tick |=> ang_fresh_q && st_fresh_q && spd_fresh_q && tmp_int_q)
    else $error("refreshed flags not set by update");

  status_fresh_a: assert property (@(posedge clk) disable iff (!rst_n)
    rd_status |=> rd_valid_q && rd_data_q[BIT_REFRESHED] == $past(st_fresh_q))
    else $error("status refreshed bit wrong");

  speed_reserved_a: assert property (@(posedge clk) disable iff (!rst_n)
    $past(rd_speed) |-> rd_data_q[14:12] == 3'h0)
    else $error("speed reserved bits not zero");

  temp_reserved_a: assert property (@(posedge clk) disable iff (!rst_n)
    $past(rd_temp) |-> rd_data_q[3:0] == 4'h0)
    else $error("temperature reserved bits not zero");

  status_reserved_a: assert property (@(posedge clk) disable iff (!rst_n)
    $past(rd_status) |-> rd_data_q[14] == 1'b0 && rd_data_q[11:10] == 2'h0)
    else $error("status reserved bits not zero");

  update_period_a: assert property (@(posedge clk) disable iff (!rst_n)
    update_q |=> !update_q [*2])
    else $error("update pulses too close");

  fsm_take_a: assert property (@(posedge clk) disable iff (!rst_n)
    temp_fsm_take && !tick |=> !tmp_fsm_q)
    else $error("internal fresh flag not cleared");

  angle_data_a: assert property (@(posedge clk) disable iff (!rst_n)
    rd_angle |=> rd_data_q[14:0] == $past(sample_q.angle_word))
    else $error("angle value wrong");

  vec_fault_a: assert property (@(posedge clk) disable iff (!rst_n)
    rd_status |=> rd_data_q[BIT_VEC_FAULT] == $past(flags_q.vector_magnitude_fault))
    else $error("vector fault bit wrong");

  answer_pulse_a: assert property (@(posedge clk) disable iff (!rst_n)
    rd_valid_q == $past(cmd_valid))
    else $error("answer strobe not one cycle after command");

  unknown_zero_a: assert property (@(posedge clk) disable iff (!rst_n)
    cmd_valid && sel == SEL_NONE |=> rd_data_q == RESET_WORD)
    else $error("unknown command answer not zero");

  cosine_data_a: assert property (@(posedge clk) disable iff (!rst_n)
    sel == SEL_COSINE |=> rd_data_q == $past(sample_q.cosine))
    else $error("cosine value wrong");

  sine_data_a: assert property (@(posedge clk) disable iff (!rst_n)
    sel == SEL_SINE |=> rd_data_q == $past(sample_q.sine))
    else $error("sine value wrong");

  speed_data_a: assert property (@(posedge clk) disable iff (!rst_n)
    rd_speed |=> rd_data_q[SPEED_W-1:0] == $past(sample_q.rotation_rate)
      && rd_data_q[BIT_REFRESHED] == $past(spd_fresh_q))
    else $error("speed word wrong");

  temp_data_a: assert property (@(posedge clk) disable iff (!rst_n)
    rd_temp |=> rd_data_q[15:TEMP_LSB] == $past(sample_q.temperature))
    else $error("temperature value wrong");

  temp_flags_a: assert property (@(posedge clk) disable iff (!rst_n)
    rd_temp |=> rd_data_q[BIT_TEMP_FSM] == $past(tmp_fsm_q)
      && rd_data_q[BIT_TEMP_INT] == $past(tmp_int_q))
    else $error("temperature fresh bits wrong");

  angle_fresh_a: assert property (@(posedge clk) disable iff (!rst_n)
    rd_angle |=> rd_data_q[BIT_REFRESHED] == $past(ang_fresh_q))
    else $error("angle refreshed bit wrong");

  if_fault_a: assert property (@(posedge clk) disable iff (!rst_n)
    rd_status |=> rd_data_q[BIT_IF_FAULT] == $past(flags_q.if_fault))
    else $error("interface fault bit wrong");

  nvm_fault_a: assert property (@(posedge clk) disable iff (!rst_n)
    rd_status |=> rd_data_q[BIT_NVM_FAULT] == $past(flags_q.nvm_fault))
    else $error("memory fault bit wrong");

  crc_fault_a: assert property (@(posedge clk) disable iff (!rst_n)
    rd_status |=> rd_data_q[BIT_CRC_FAULT] == $past(flags_q.crc_fault))
    else $error("bit error alarm bit wrong");

  core_fault_a: assert property (@(posedge clk) disable iff (!rst_n)
    rd_status |=> rd_data_q[BIT_CORE_FAULT] == $past(flags_q.processing_core_fault))
    else $error("core fault bit wrong");

  selftest_bit_a: assert property (@(posedge clk) disable iff (!rst_n)
    rd_status |=> rd_data_q[BIT_SELFTEST] == $past(flags_q.selftest_fault))
    else $error("self test bit wrong");

  temp_fault_a: assert property (@(posedge clk) disable iff (!rst_n)
    rd_status |=> rd_data_q[BIT_TEMP_FAULT] == $past(flags_q.temperature_fault))
    else $error("temperature fault bit wrong");

  adc_fault_a: assert property (@(posedge clk) disable iff (!rst_n)
    rd_status |=> rd_data_q[BIT_ADC_FAULT] == $past(flags_q.adc_fault))
    else $error("converter fault bit wrong");

  supply_fault_a: assert property (@(posedge clk) disable iff (!rst_n)
    rd_status |=> rd_data_q[BIT_SUPPLY_FAULT] == $past(flags_q.supply_fault))
    else $error("supply fault bit wrong");

  wdog_bit_a: assert property (@(posedge clk) disable iff (!rst_n)
    rd_status |=> rd_data_q[BIT_WDOG] == $past(flags_q.watchdog_reset_seen))
    else $error("watchdog reset bit wrong");

  redundancy_bit_a: assert property (@(posedge clk) disable iff (!rst_n)
    rd_status |=> rd_data_q[BIT_REDUNDANCY] == $past(flags_q.redundancy_mismatch))
    else $error("redundancy bit wrong");

endmodule // aswr_regs

// >>> sim/aswr_master_model.sv
// Behavioural calibration port master that issues read commands
module aswr_master_model
  import aswr_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Bench side
  input  wire logic        req,
  input  wire logic [15:0] req_code,
  output logic             done_q,
  output logic [15:0]      data_q,
  // Command port
  output logic             cmd_valid,
  output logic [15:0]      cmd_code,
  input  wire logic        rd_valid_q,
  input  wire logic [15:0] rd_data_q
);
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================================================
  // Command launch; the code lines scramble once the pulse is over
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cmd_valid <= 1'b0;
      cmd_code  <= 16'h5a5a;
    end else if (req) begin
      cmd_valid <= 1'b1;
      cmd_code  <= req_code;
    end else begin
      cmd_valid <= 1'b0;
      if (cmd_valid) cmd_code <= ~cmd_code;
    end
  end

  // ==========================================================================
  // Answer capture
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      done_q <= 1'b0;
      data_q <= 16'h0000;
    end else begin
      done_q <= rd_valid_q;
      if (rd_valid_q) data_q <= rd_data_q;
    end
  end
endmodule // aswr_master_model

// >>> sim/angle_sensor_working_registers_test.sv
// Self-checking bench for the angle working register set
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin miscompares++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e); end end
module angle_sensor_working_registers_test
  import aswr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int UPD = 64;
  logic         clk = 1'b0;
  logic         rst_n = 1'b0;
  aswr_flags_t  flags = '0;
  aswr_sample_t smp = '0;
  logic         take = 1'b0;
  logic         req = 1'b0;
  logic [15:0]  req_code = 16'h0000;
  logic         cmd_valid, rd_valid_q, update_q, m_done;
  logic [15:0]  cmd_code, rd_data_q, m_data;
  int           miscompares = 0;
  int           check_count = 0;
  int           n;
  logic [15:0]  codes [7] = '{CMD_STATUS, CMD_ANGLE, CMD_SPEED, CMD_COSINE, CMD_SINE,
                                CMD_TEMP, 16'hc011};

  always #5 clk = ~clk;

  aswr_regs #(.UPDATE_CYCLES(UPD)) dut_u (
    .clk(clk), .rst_n(rst_n), .flags_in(flags), .sample_in(smp), .temp_fsm_take(take),
    .cmd_valid(cmd_valid), .cmd_code(cmd_code), .rd_valid_q(rd_valid_q),
    .rd_data_q(rd_data_q), .update_q(update_q));

  aswr_master_model master_u (
    .clk(clk), .rst_n(rst_n), .req(req), .req_code(req_code), .done_q(m_done),
    .data_q(m_data), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
    .rd_valid_q(rd_valid_q), .rd_data_q(rd_data_q));

  // ==========================================================================
  // Tasks
  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input logic [15:0] code, input logic [15:0] exp);
    int i;
    @(posedge clk);
    req      <= 1'b1;
    req_code <= code;
    @(posedge clk);
    req <= 1'b0;
    for (i = 0; i < 20; i++) begin
      @(negedge clk);
      if (m_done === 1'b1) break;
    end
    if (i == 20) begin
      miscompares++;
      end_sim();
    end else begin
      `CHK(m_data, exp)
    end
  endtask

  // Counts cycles up to the next update pulse
  task automatic wait_update(output int c);
    for (c = 1; c <= 200; c++) begin
      @(negedge clk);
      if (update_q === 1'b1) break;
    end
    if (c > 200) begin
      miscompares++;
      end_sim();
    end
  endtask

  function automatic logic [15:0] stat(input logic [11:0] f, input logic fresh);
    return {fresh, 1'b0, f[11:10], 2'b00, f[9:0]};
  endfunction

  // ==========================================================================
  // Sequence
  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    foreach (codes[i]) chk(codes[i], 16'h0000);
    $display("test reset_values done");
    @(posedge clk);
    flags <= 12'ha5c;
    smp   <= {15'h4000, 12'h801, 16'hffff, 16'h1234, 10'h3ff};
    wait_update(n);
    wait_update(n);
    chk(CMD_STATUS, stat(12'ha5c, 1'b1));
    chk(CMD_STATUS, stat(12'ha5c, 1'b0));
    chk(16'hc011, 16'h0000);
    chk(CMD_ANGLE, {1'b1, 15'h4000});
    chk(CMD_ANGLE, {1'b0, 15'h4000});
    chk(CMD_SPEED, {1'b1, 3'b000, 12'h801});
    chk(CMD_COSINE, 16'hffff);
    chk(CMD_SINE, 16'h1234);
    @(posedge clk);
    take <= 1'b1;
    @(posedge clk);
    take <= 1'b0;
    chk(CMD_TEMP, {10'h3ff, 2'b01, 4'h0});
    chk(CMD_TEMP, {10'h3ff, 6'h00});
    $display("test first_update done");
    @(posedge clk);
    flags           <= 12'h5a3;
    smp.angle_word  <= 15'h3fff;
    wait_update(n);
    wait_update(n);
    `CHK(n, UPD)
    chk(CMD_STATUS, stat(12'h5a3, 1'b1));
    chk(CMD_ANGLE, {1'b1, 15'h3fff});
    chk(CMD_TEMP, {10'h3ff, 2'b11, 4'h0});
    chk(CMD_SPEED, {1'b1, 3'b000, 12'h801});
    chk(CMD_SPEED, {1'b0, 3'b000, 12'h801});
    $display("test refresh done");
    end_sim();
  end
endmodule // angle_sensor_working_registers_test
